// file: src/acs_format.sv
// Output word coding and clamping of the filter result
`default_nettype none
module acs_format (
    input wire logic [acs_pkg::RAW_W-1:0] filter_raw,
    input wire logic bipolar,
    output logic [acs_pkg::WORD_W-1:0] word
);
    logic signed [acs_pkg::RAW_W:0] sum;
    always_comb begin
        sum = $signed({filter_raw[acs_pkg::RAW_W-1], filter_raw});
        if (bipolar) begin
            sum = sum + $signed({2'h0, acs_pkg::BIPOLAR_OFFSET});
        end
        if (sum < 0) begin
            word = acs_pkg::CODE_MIN;
        end else if (sum > $signed({3'h0, acs_pkg::CODE_MAX})) begin
            word = acs_pkg::CODE_MAX;
        end else begin
            word = sum[acs_pkg::WORD_W-1:0];
        end
    end
endmodule : acs_format
`default_nettype wire

// file: src/acs_pkg.sv
// Shared constants and types of the conversion sequencer
`default_nettype none
package acs_pkg;
    localparam int CNT_W = 12;
    localparam int RAW_W = 18;
    localparam int WORD_W = 16;
    localparam int IRQ_W = 3;
    // Durations in master clock cycles
    localparam logic [CNT_W-1:0] WAKE_CYC = 12'h708;
    localparam logic [CNT_W-1:0] CAL_CYC = 12'hcae;
    localparam logic [CNT_W-1:0] CONVERT_REQUEST_CYC = 12'h656;
    localparam logic [CNT_W-1:0] FIRST_CYC = 12'h658;
    localparam logic [CNT_W-1:0] READY_LEAD = 12'h002;
    // Result formatting
    localparam logic [WORD_W:0] BIPOLAR_OFFSET = 17'h08000;
    localparam logic [WORD_W-1:0] CODE_MAX = 16'hffff;
    localparam logic [WORD_W-1:0] CODE_MIN = 16'h0000;
    // Register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_RESULT = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    // Interrupt bits
    localparam int IRQ_LOADED = 0;
    localparam int IRQ_CAL_DONE = 1;
    localparam int IRQ_ABORT = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    typedef enum logic [3:0] {
        ACS_WAKE = 4'h1,
        ACS_STANDBY = 4'h2,
        ACS_CAL = 4'h4,
        ACS_CONVERT_REQUEST = 4'h8
    } acs_state_type;
endpackage : acs_pkg
`default_nettype wire

// file: src/acs_sequencer.sv
// Calibration and conversion sequencer with AHB-Lite status registers
`default_nettype none
module acs_sequencer (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic master_clock_in,
    input wire logic convert_request,
    input wire logic calibrate_request,
    input wire logic polarity_select,
    input wire logic [acs_pkg::RAW_W-1:0] filter_raw,
    input wire logic port_empty,
    input wire logic port_deselected,
    input wire logic port_read_done,
    output logic result_ready_n,
    output logic [acs_pkg::WORD_W-1:0] result_word,
    output logic irq,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata
);
    typedef struct packed {
        acs_pkg::acs_state_type state;
        logic [acs_pkg::CNT_W-1:0] count;
        logic [acs_pkg::CNT_W-1:0] len;
        logic phase;
        logic clk_prev;
        logic convert_request_prev;
        logic ready_n;
        logic load_ok;
        logic [acs_pkg::WORD_W-1:0] result;
        logic [acs_pkg::IRQ_W-1:0] irq_stat;
        logic [acs_pkg::IRQ_W-1:0] irq_mask;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] rd_addr;
    } acs_seq_type;

    acs_seq_type st;
    acs_seq_type next_st;
    logic [3:0] pins_sync;
    logic clk_s;
    logic convert_request_s;
    logic cal_s;
    logic bipolar_s;
    logic edge_m;
    logic tick;
    logic period_end;
    logic ready_pre;
    logic convert_request_rise;
    logic [acs_pkg::WORD_W-1:0] fmt_word;
    logic [acs_pkg::IRQ_W-1:0] irq_set;
    logic [acs_pkg::IRQ_W-1:0] irq_clr;

    // Pins are asynchronous to clk_sys
    acs_sync #(.WIDTH(4)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in({master_clock_in, convert_request, calibrate_request, polarity_select}),
        .pin_sync(pins_sync)
    );
    assign {clk_s, convert_request_s, cal_s, bipolar_s} = pins_sync;

    // Polarity read live at load time, never held
    acs_format u_format (
        .filter_raw(filter_raw),
        .bipolar(bipolar_s),
        .word(fmt_word)
    );

    assign edge_m = clk_s & ~st.clk_prev;
    assign tick = edge_m & st.phase;
    assign period_end = edge_m && (st.count == st.len - 12'h001);
    assign ready_pre = edge_m && (st.count == st.len - acs_pkg::READY_LEAD - 12'h001);
    // Rise seen at half-rate resolution only
    assign convert_request_rise = tick & convert_request_s & ~st.convert_request_prev;

    always_comb begin
        next_st = st;
        irq_set = '0;
        irq_clr = '0;
        next_st.clk_prev = clk_s;
        if (edge_m) begin
            next_st.phase = ~st.phase;
            next_st.count = st.count + 12'h001;
        end
        if (tick) begin
            next_st.convert_request_prev = convert_request_s;
        end
        if (port_read_done) begin
            next_st.ready_n = 1'b1;
        end
        case (st.state)
            acs_pkg::ACS_WAKE: begin
                if (period_end) begin
                    next_st.state = acs_pkg::ACS_STANDBY;
                end
            end
            acs_pkg::ACS_STANDBY: begin
                if (tick && convert_request_s && cal_s) begin
                    next_st.state = acs_pkg::ACS_CAL;
                    next_st.count = '0;
                    next_st.len = acs_pkg::CAL_CYC;
                end else if (tick && convert_request_s) begin
                    next_st.state = acs_pkg::ACS_CONVERT_REQUEST;
                    next_st.count = '0;
                    next_st.len = acs_pkg::FIRST_CYC;
                end
            end
            acs_pkg::ACS_CAL: begin
                if (convert_request_rise && cal_s) begin
                    next_st.count = '0;
                end else if (period_end) begin
                    irq_set[acs_pkg::IRQ_CAL_DONE] = 1'b1;
                    next_st.count = '0;
                    if (convert_request_s) begin
                        next_st.state = acs_pkg::ACS_CONVERT_REQUEST;
                        next_st.len = acs_pkg::CONVERT_REQUEST_CYC;
                    end else begin
                        next_st.state = acs_pkg::ACS_STANDBY;
                    end
                end
            end
            acs_pkg::ACS_CONVERT_REQUEST: begin
                if (convert_request_rise) begin
                    irq_set[acs_pkg::IRQ_ABORT] = 1'b1;
                    next_st.count = '0;
                    if (cal_s) begin
                        next_st.state = acs_pkg::ACS_CAL;
                        next_st.len = acs_pkg::CAL_CYC;
                    end else begin
                        next_st.len = acs_pkg::CONVERT_REQUEST_CYC;
                    end
                end else if (period_end) begin
                    if (st.load_ok) begin
                        next_st.result = fmt_word;
                        next_st.ready_n = 1'b0;
                        irq_set[acs_pkg::IRQ_LOADED] = 1'b1;
                    end
                    next_st.count = '0;
                    if (convert_request_s && cal_s) begin
                        next_st.state = acs_pkg::ACS_CAL;
                        next_st.len = acs_pkg::CAL_CYC;
                    end else if (convert_request_s) begin
                        next_st.len = acs_pkg::CONVERT_REQUEST_CYC;
                    end else begin
                        next_st.state = acs_pkg::ACS_STANDBY;
                    end
                end else if (ready_pre) begin
                    next_st.ready_n = 1'b1;
                    next_st.load_ok = port_empty | port_deselected;
                end
            end
            default: begin
                next_st.state = acs_pkg::ACS_STANDBY;
            end
        endcase
        // Bus data phase: one-cycle write after address phase
        next_st.wr_pend = 1'b0;
        if (hsel && hready && htrans == acs_pkg::HTRANS_NONSEQ) begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = haddr[7:0];
            next_st.rd_addr = haddr[7:0];
        end
        if (st.wr_pend && st.wr_addr == acs_pkg::REG_IRQ_MASK) begin
            next_st.irq_mask = hwdata[acs_pkg::IRQ_W-1:0];
        end
        if (st.wr_pend && st.wr_addr == acs_pkg::REG_IRQ_STATUS) begin
            irq_clr = hwdata[acs_pkg::IRQ_W-1:0];
        end
        // Set wins over a simultaneous clear
        next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '{state: acs_pkg::ACS_WAKE, len: acs_pkg::WAKE_CYC,
                    ready_n: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        case (st.rd_addr)
            acs_pkg::REG_STATUS: begin
                hrdata = {26'h0, st.load_ok, st.ready_n, st.state};
            end
            acs_pkg::REG_RESULT: begin
                hrdata = {16'h0000, st.result};
            end
            acs_pkg::REG_IRQ_STATUS: begin
                hrdata = {29'h0, st.irq_stat};
            end
            acs_pkg::REG_IRQ_MASK: begin
                hrdata = {29'h0, st.irq_mask};
            end
            default: begin
                hrdata = 32'h00000000;
            end
        endcase
    end

    assign hreadyout = 1'b1;
    assign hresp = acs_pkg::HRESP_OKAY;
    assign irq = |(st.irq_stat & st.irq_mask);
    assign result_ready_n = st.ready_n;
    assign result_word = st.result;

    // Checks
    AST_WAKE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_WAKE && next_st.state != acs_pkg::ACS_WAKE
        |-> st.count == acs_pkg::WAKE_CYC - 12'h001 && edge_m)
        else $error("wake-up ended early");
    AST_CAL_ENTRY: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_STANDBY && tick && convert_request_s && cal_s
        |=> st.state == acs_pkg::ACS_CAL && st.count == '0)
        else $error("calibration not entered");
    AST_CAL_LEN: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CAL ##1 st.state != acs_pkg::ACS_CAL
        |-> $past(st.count) == acs_pkg::CAL_CYC - 12'h001)
        else $error("calibration length wrong");
    AST_CAL_TO_CONVERT_REQUEST: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CAL && period_end && convert_request_s && !convert_request_rise
        |=> st.state == acs_pkg::ACS_CONVERT_REQUEST && st.len == acs_pkg::CONVERT_REQUEST_CYC)
        else $error("no conversion after calibration");
    AST_FIRST_LEN: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_STANDBY ##1 st.state == acs_pkg::ACS_CONVERT_REQUEST
        |-> st.len == acs_pkg::FIRST_CYC)
        else $error("standby conversion length wrong");
    AST_READY_LEAD: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && ready_pre && !convert_request_rise
        |=> st.ready_n && st.load_ok == ($past(port_empty) | $past(port_deselected)))
        else $error("ready not raised ahead of update");
    AST_LOAD_GATE: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(st.ready_n) |-> $past(st.load_ok) && $past(period_end))
        else $error("word loaded into busy port");
    AST_ABORT: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && convert_request_rise && !cal_s
        |=> st.state == acs_pkg::ACS_CONVERT_REQUEST && st.count == '0)
        else $error("conversion not restarted");
    AST_STANDBY_RET: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && period_end && !convert_request_s
        |=> st.state == acs_pkg::ACS_STANDBY)
        else $error("no return to standby");
    AST_CLAMP_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
        !filter_raw[acs_pkg::RAW_W-1] && filter_raw[acs_pkg::RAW_W-2:acs_pkg::WORD_W] != '0
        |-> fmt_word == acs_pkg::CODE_MAX)
        else $error("over-range not clamped");
    AST_IRQ_LOADED: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(st.ready_n) |-> st.irq_stat[acs_pkg::IRQ_LOADED])
        else $error("load event lost");
    AST_WAKE_STAY: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_WAKE && !period_end
        |=> st.state == acs_pkg::ACS_WAKE)
        else $error("request executed during wake-up");
    AST_CONVERT_REQUEST_ENTRY: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_STANDBY && tick && convert_request_s && !cal_s
        |=> st.state == acs_pkg::ACS_CONVERT_REQUEST && st.count == '0)
        else $error("conversion not entered from standby");
    AST_CAL_RESTART: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CAL && convert_request_rise && cal_s
        |=> st.state == acs_pkg::ACS_CAL && st.count == '0)
        else $error("calibration not restarted");
    AST_CAL_TO_STANDBY: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CAL && period_end && !convert_request_s
        |=> st.state == acs_pkg::ACS_STANDBY)
        else $error("no standby after calibration");
    AST_CONVERT_REQUEST_LEN: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && period_end && convert_request_s && !cal_s
        |=> st.state == acs_pkg::ACS_CONVERT_REQUEST && st.len == acs_pkg::CONVERT_REQUEST_CYC)
        else $error("continuous conversion length wrong");
    AST_ABORT_CAL: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && convert_request_rise && cal_s
        |=> st.state == acs_pkg::ACS_CAL && st.len == acs_pkg::CAL_CYC)
        else $error("abort with calibrate did not calibrate");
    AST_CONVERT_REQUEST_CAL: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && period_end && convert_request_s && cal_s
        |=> st.state == acs_pkg::ACS_CAL)
        else $error("calibration not entered after conversion");
    AST_NO_LOAD_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && period_end && !convert_request_rise && !st.load_ok
        |=> st.result == $past(st.result))
        else $error("word loaded into busy port");
    AST_LOAD_WORD: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && period_end && !convert_request_rise && st.load_ok
        |=> st.result == $past(fmt_word) && !st.ready_n)
        else $error("finished word not loaded");
    AST_RESULT_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        !(st.state == acs_pkg::ACS_CONVERT_REQUEST && period_end)
        |=> st.result == $past(st.result))
        else $error("result changed outside a load");
    AST_CLAMP_LOW: assert property (@(posedge clk_sys) disable iff (reset)
        filter_raw[acs_pkg::RAW_W-1] && !bipolar_s
        |-> fmt_word == acs_pkg::CODE_MIN)
        else $error("under-range not clamped");
    AST_STRAIGHT: assert property (@(posedge clk_sys) disable iff (reset)
        !bipolar_s && filter_raw[acs_pkg::RAW_W-1:acs_pkg::WORD_W] == '0
        |-> fmt_word == filter_raw[acs_pkg::WORD_W-1:0])
        else $error("unipolar word not straight binary");
    AST_OFFSET: assert property (@(posedge clk_sys) disable iff (reset)
        bipolar_s && &filter_raw[acs_pkg::RAW_W-1:acs_pkg::WORD_W-1]
        |-> fmt_word == {1'h0, filter_raw[acs_pkg::WORD_W-2:0]})
        else $error("bipolar offset wrong");
    AST_CAL_DONE_IRQ: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CAL && period_end && !(convert_request_rise && cal_s)
        |=> st.irq_stat[acs_pkg::IRQ_CAL_DONE])
        else $error("calibration end event lost");
    AST_ABORT_IRQ: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && convert_request_rise
        |=> st.irq_stat[acs_pkg::IRQ_ABORT])
        else $error("abort event lost");
    AST_READY_RISE: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(st.ready_n) |-> $past(port_read_done) || $past(ready_pre))
        else $error("ready raised without cause");
    // Full but deselected port still takes the new word
    COV_DESEL_LOAD: cover property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && ready_pre && !port_empty && port_deselected);
    COV_CAL_THEN_CONVERT_REQUEST: cover property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CAL ##1 st.state == acs_pkg::ACS_CONVERT_REQUEST);
    COV_LOAD: cover property (@(posedge clk_sys) disable iff (reset) $fell(st.ready_n));
    COV_ABORT: cover property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && convert_request_rise);
    COV_SKIP: cover property (@(posedge clk_sys) disable iff (reset)
        st.state == acs_pkg::ACS_CONVERT_REQUEST && period_end && !st.load_ok);
endmodule : acs_sequencer
`default_nettype wire

// file: src/acs_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`default_nettype none
module acs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } acs_sync_type;
    acs_sync_type st;
    acs_sync_type next_st;
    always_comb begin
        next_st.stage1 = pin_in;
        next_st.stage2 = st.stage1;
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign pin_sync = st.stage2;
endmodule : acs_sync
`default_nettype wire

// file: verif/acs_port_model.sv
// Serial port stand-in that empties each loaded word unless stalled or parked
`default_nettype none
module acs_port_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic result_ready_n,
    input wire logic stall,
    input wire logic park,
    output logic port_empty,
    output logic port_deselected,
    output logic port_read_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rdy_q;
    logic [2:0] cnt;
    // Selected while stalled, so a held word blocks the next load
    // Parked: word kept unread with the port deselected
    assign port_deselected = (port_empty && !stall) || park;
    always_ff @(posedge clk_sys) begin
        rdy_q <= result_ready_n;
        port_read_done <= 1'b0;
        if (reset) begin
            port_empty <= 1'b1;
            cnt <= 3'h0;
        end else if (rdy_q && !result_ready_n) begin
            port_empty <= 1'b0;
        end else if (!port_empty && !stall && !park) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) begin
                port_read_done <= 1'b1;
                port_empty <= 1'b1;
            end
        end
    end
endmodule : acs_port_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the conversion sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, reset, master_clock_in, convert_request, calibrate_request;
    logic polarity_select, port_empty, port_deselected, port_read_done;
    logic result_ready_n, irq, stall, park, hsel, hwrite, hreadyout, rdy_q;
    logic [17:0] filter_raw;
    logic [15:0] result_word;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize;
    int err_total = 0;
    int n_tests = 0;
    int medge = 0;
    int nf = 0;
    int tf, tr, t1, k;
    acs_sequencer uut (.clk_sys(clk_sys), .reset(reset), .master_clock_in(master_clock_in),
        .convert_request(convert_request), .calibrate_request(calibrate_request),
        .polarity_select(polarity_select), .filter_raw(filter_raw), .port_empty(port_empty),
        .port_deselected(port_deselected), .port_read_done(port_read_done),
        .result_ready_n(result_ready_n), .result_word(result_word), .irq(irq), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    acs_port_model u_port (.clk_sys(clk_sys), .reset(reset), .result_ready_n(result_ready_n),
        .stall(stall), .park(park), .port_empty(port_empty), .port_deselected(port_deselected),
        .port_read_done(port_read_done));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Slow master clock, three system cycles per half period keeps the run short
    initial begin
        master_clock_in = 1'b0;
        forever begin
            repeat (3) @(posedge clk_sys);
            if (!master_clock_in && !reset) medge++;
            master_clock_in <= ~master_clock_in;
        end
    end
    always @(posedge clk_sys) begin
        rdy_q <= result_ready_n;
        if (!reset && rdy_q === 1'b1 && result_ready_n === 1'b0) begin
            nf <= nf + 1;
            tf <= medge;
        end
        if (!reset && rdy_q === 1'b0 && result_ready_n === 1'b1) tr <= medge;
    end
    task complete_run();
        $display("Errors %0d, checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task win(input int v, input int lo, input int hi);
        chk({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask : win
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= acs_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask : ahb
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({30'h0, hresp}, {30'h0, acs_pkg::HRESP_OKAY});
    endtask : rdchk
    task st(input logic [3:0] exp);
        ahb(1'b0, acs_pkg::REG_STATUS, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, exp});
    endtask : st
    task irqchk(input logic exp);
        @(negedge clk_sys);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irqchk
    task wait_m(input int n);
        int s;
        s = medge;
        while (medge < s + n) @(posedge clk_sys);
    endtask : wait_m
    task wait_fall();
        int c;
        c = nf;
        while (nf == c) @(posedge clk_sys);
        @(posedge clk_sys);
    endtask : wait_fall
    // Hang guard, well past the longest expected run
    initial begin
        repeat (95000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        convert_request = 1'b0;
        calibrate_request = 1'b0;
        polarity_select = 1'b1;
        filter_raw = 18'h3fff0;
        stall = 1'b0;
        park = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(acs_pkg::REG_STATUS, 32'h11);
        rdchk(8'h10, 32'h0);
        rdchk(acs_pkg::REG_IRQ_MASK, 32'h0);
        ahb(1'b1, acs_pkg::REG_IRQ_MASK, 32'hffffffff);
        rdchk(acs_pkg::REG_IRQ_MASK, 32'h7);
        wait_m(1000);
        calibrate_request <= 1'b1;
        convert_request <= 1'b1;
        wait_m(690);
        st(4'h1);
        wait_m(140);
        st(4'h4);
        calibrate_request <= 1'b0;
        wait_fall();
        win(tf, 6666, 6676);
        chk({16'h0, result_word}, 32'h7ff0);
        // Polarity changes right after the fall keep the next word clean
        polarity_select <= 1'b0;
        filter_raw <= 18'h01234;
        rdchk(acs_pkg::REG_IRQ_STATUS, 32'h3);
        irqchk(1'b1);
        ahb(1'b1, acs_pkg::REG_IRQ_STATUS, 32'h3);
        t1 = tf;
        wait_fall();
        chk(tf - t1, 1622);
        chk({16'h0, result_word}, 32'h1234);
        stall <= 1'b1;
        convert_request <= 1'b0;
        filter_raw <= 18'h00abc;
        wait_m(1630);
        chk(tr - tf, 1620);
        chk({31'h0, result_ready_n}, 32'h1);
        chk({16'h0, result_word}, 32'h1234);
        st(4'h2);
        // Old word stays unread but deselected, so the next one must load
        stall <= 1'b0;
        park <= 1'b1;
        filter_raw <= 18'h10000;
        ahb(1'b1, acs_pkg::REG_IRQ_STATUS, 32'h7);
        convert_request <= 1'b1;
        t1 = medge;
        wait_m(50);
        convert_request <= 1'b0;
        wait_fall();
        win(tf - t1, 1624, 1630);
        chk({16'h0, result_word}, 32'hffff);
        park <= 1'b0;
        filter_raw <= 18'h3fff0;
        convert_request <= 1'b1;
        wait_m(200);
        convert_request <= 1'b0;
        wait_m(10);
        convert_request <= 1'b1;
        t1 = medge;
        k = nf;
        wait_m(50);
        convert_request <= 1'b0;
        wait_fall();
        win(tf - t1, 1622, 1628);
        chk(nf - k, 1);
        chk({16'h0, result_word}, 32'h0);
        rdchk(acs_pkg::REG_IRQ_STATUS, 32'h5);
        irqchk(1'b1);
        ahb(1'b1, acs_pkg::REG_IRQ_MASK, 32'h0);
        irqchk(1'b0);
        ahb(1'b1, acs_pkg::REG_IRQ_MASK, 32'h4);
        irqchk(1'b1);
        ahb(1'b1, acs_pkg::REG_IRQ_STATUS, 32'h5);
        rdchk(acs_pkg::REG_IRQ_STATUS, 32'h0);
        irqchk(1'b0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
